//--- common/rfq_pkg.sv
/*
  Package for the radio FIFO and packet block: register offsets, field
  positions, reset values, timing constants, state codes and carriers.
  Assumes a single 40 MHz system clock and a byte-wide register space.
*/
package rfq_pkg;
  // Register offsets on the serial port
  localparam logic [6:0] ADR_STATUS = 7'h03;
  localparam logic [6:0] ADR_IRQ_EN = 7'h05;
  localparam logic [6:0] ADR_OPMODE = 7'h07;
  localparam logic [6:0] ADR_FC2 = 7'h08;
  localparam logic [6:0] ADR_PKCTRL = 7'h30;
  localparam logic [6:0] ADR_PRELEN = 7'h34;
  localparam logic [6:0] ADR_SYNC_HI = 7'h36;
  localparam logic [6:0] ADR_SYNC_LO = 7'h37;
  localparam logic [6:0] ADR_TXHDR = 7'h3a;
  localparam logic [6:0] ADR_PKLEN = 7'h3e;
  localparam logic [6:0] ADR_MODCTL = 7'h70;
  localparam logic [6:0] ADR_TXAF = 7'h7c;
  localparam logic [6:0] ADR_TXAE = 7'h7d;
  localparam logic [6:0] ADR_RXAF = 7'h7e;
  localparam logic [6:0] ADR_FIFO = 7'h7f;
  // Field positions
  localparam int OPM_XTON = 0;
  localparam int OPM_PLLON = 1;
  localparam int OPM_RXON = 2;
  localparam int OPM_TXON = 3;
  localparam int FC2_CLRTX = 0;
  localparam int FC2_CLRRX = 1;
  localparam int PKC_ENRX = 7;
  localparam int PKC_ENTX = 3;
  localparam int PKC_ENCRC = 2;
  localparam int MOD_MANCH = 1;
  localparam int ST_TXAF = 6;
  localparam int ST_TXAE = 5;
  localparam int ST_RXAF = 4;
  localparam int ST_PKSENT = 2;
  localparam int ST_PKVALID = 1;
  // Reset values, preamble byte and the transmit-only mode value
  localparam logic [7:0] RST_TXAF = 8'h37;
  localparam logic [7:0] RST_TXAE = 8'h04;
  localparam logic [7:0] RST_RXAF = 8'h37;
  localparam logic [7:0] RST_PKCTRL = 8'h8d;
  localparam logic [7:0] RST_PRELEN = 8'h08;
  localparam logic [7:0] RST_SYNC_HI = 8'h2d;
  localparam logic [7:0] RST_SYNC_LO = 8'hd4;
  localparam logic [7:0] PRE_BYTE = 8'h55;
  localparam logic [7:0] OPM_TXON_ONLY = 8'h08;
  // FIFO geometry and preamble detection length
  localparam int FIFO_AW = 6;
  localparam logic [FIFO_AW:0] FIFO_DEPTH = 7'h40;
  localparam logic [2:0] PRE_MIN_BITS = 3'h7;
  // Bit timing
  localparam int CLK_NS = 25;
  localparam int BIT_NS = 100000;
  localparam int BIT_CYC = BIT_NS / CLK_NS;
  localparam logic [11:0] BIT_LAST = 12'(BIT_CYC - 1);
  // Transmit sequencer states
  typedef enum logic [6:0] {
    TX_IDLE = 7'b0000001, TX_PRE = 7'b0000010, TX_SYNC = 7'b0000100,
    TX_HDR = 7'b0001000, TX_LEN = 7'b0010000, TX_DATA = 7'b0100000,
    TX_CRC = 7'b1000000
  } rfq_tx_state_type;
  // Receive phases
  typedef enum logic [4:0] {
    RX_HUNT = 5'b00001, RX_HDR = 5'b00010, RX_LEN = 5'b00100,
    RX_DATA = 5'b01000, RX_CHK = 5'b10000
  } rfq_rx_state_type;
  // Pins sampled from outside the clock domain
  typedef struct packed {
    logic sclk;
    logic nsel_n;
    logic sdi;
    logic rx_data;
  } rfq_pins_type;
endpackage

//--- verilog/rfq_top.sv
/*
  Radio FIFO block: serial register port, 64-byte transmit and receive
  FIFOs, threshold events, interrupt line, transmit packet sequencer
  with automatic mode exit, and raw or packet receive path.
  Assumes the serial port clock and receive data are asynchronous and
  much slower than clk_sys; one bit time per BIT_CYC system cycles.
*/
`timescale 1ns/1ps
module rfq_top
  import rfq_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic spi_sclk,
  input wire logic spi_nsel_n,
  input wire logic spi_sdi,
  output logic spi_sdo,
  input wire logic rf_rx_data,
  output logic rf_tx_data,
  output logic tx_active,
  output logic interrupt_line_n,
  output logic general_pin_two
);
  rfq_pins_type pin_meta_q, pin_sync_q;
  logic sclk_d_q, spi_first_q, spi_wr_q, sdo_q, irq_n_q, mclk_q, txd_q;
  logic [2:0] spi_cnt_q;
  logic [6:0] spi_addr_q, rd_addr;
  logic [7:0] spi_in_q, spi_out_q, spi_byte, rd_data;
  logic sclk_rise, sclk_fall, byte_done, wr_stb, rd_stb;
  logic [7:0] status_q, irq_en_q, opmode_q, fc2_q, pkctrl_q, prelen_q;
  logic [7:0] sync_hi_q, sync_lo_q, txhdr_q, pklen_q, modctl_q;
  logic [7:0] txaf_q, txae_q, rxaf_q;
  logic [1:0] push, pop, clr, full, empty;
  logic [7:0] wdata [2];
  logic [7:0] rdata [2];
  logic [FIFO_AW:0] cnt [2];
  logic [FIFO_AW:0] cnt_prev_q [2];
  logic ev_txaf, ev_txae, ev_rxaf, ev_pksent, ev_pkvalid;
  logic [11:0] div_q;
  logic bit_en;
  rfq_tx_state_type tx_st_q;
  logic [7:0] tx_sh_q, tx_idx_q, tx_chk_q;
  logic [2:0] tx_bits_q;
  logic tx_done, tx_load, tx_pop;
  rfq_rx_state_type rx_st_q;
  logic [15:0] rx_sh_q;
  logic [7:0] rx_byte_q, rx_left_q, rx_chk_q, rx_nbyte;
  logic [2:0] rx_bits_q, alt_cnt_q;
  logic half_q, man_first_q, rx_bit_ok, rx_bit, pre_seen_q, rx_push;

  // Two-flop synchronisers for every pin from the host or the radio
  always_ff @(posedge clk_sys) begin
    pin_meta_q <= '{spi_sclk, spi_nsel_n, spi_sdi, rf_rx_data};
    pin_sync_q <= pin_meta_q;
    sclk_d_q <= pin_sync_q.sclk;
  end
  assign sclk_rise = pin_sync_q.sclk & ~sclk_d_q & ~pin_sync_q.nsel_n;
  assign sclk_fall = ~pin_sync_q.sclk & sclk_d_q & ~pin_sync_q.nsel_n;
  assign spi_byte = {spi_in_q[6:0], pin_sync_q.sdi};
  assign byte_done = sclk_rise && spi_cnt_q == 3'h7;
  assign wr_stb = byte_done && !spi_first_q && spi_wr_q;
  assign rd_stb = byte_done && (spi_first_q ? !spi_byte[7] : !spi_wr_q);
  // The FIFO address does not advance, so bursts stream through it
  assign rd_addr = spi_first_q ? spi_byte[6:0] :
                   (spi_addr_q == ADR_FIFO) ? spi_addr_q : spi_addr_q + 7'h1;

  // Serial port: address byte, then data bytes; sdo moves on falling edge
  always_ff @(posedge clk_sys) begin
    if (srst || pin_sync_q.nsel_n) begin
      spi_cnt_q <= 3'h0;
      spi_first_q <= 1'b1;
      spi_wr_q <= 1'b0;
      spi_addr_q <= 7'h00;
      spi_in_q <= 8'h00;
      spi_out_q <= 8'h00;
    end else if (sclk_rise) begin
      spi_in_q <= spi_byte;
      spi_cnt_q <= spi_cnt_q + 3'h1;
      if (byte_done) begin
        spi_first_q <= 1'b0;
        if (spi_first_q) begin
          spi_wr_q <= spi_byte[7];
        end
        spi_addr_q <= rd_addr;
        spi_out_q <= rd_data;
      end
    end else if (sclk_fall) begin
      spi_out_q <= {spi_out_q[6:0], 1'b0};
    end
  end

  // Output pin for serial read data
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sdo_q <= 1'b0;
    end else if (sclk_fall) begin
      sdo_q <= spi_out_q[7];
    end
  end

  // Read mux; reserved bits of the threshold registers read as zero
  always_comb begin
    rd_data = 8'h00;
    if (rd_addr == ADR_STATUS) begin
      rd_data = status_q;
    end else if (rd_addr == ADR_IRQ_EN) begin
      rd_data = irq_en_q;
    end else if (rd_addr == ADR_OPMODE) begin
      rd_data = opmode_q;
    end else if (rd_addr == ADR_FC2) begin
      rd_data = fc2_q;
    end else if (rd_addr == ADR_PKCTRL) begin
      rd_data = pkctrl_q;
    end else if (rd_addr == ADR_PRELEN) begin
      rd_data = prelen_q;
    end else if (rd_addr == ADR_SYNC_HI) begin
      rd_data = sync_hi_q;
    end else if (rd_addr == ADR_SYNC_LO) begin
      rd_data = sync_lo_q;
    end else if (rd_addr == ADR_TXHDR) begin
      rd_data = txhdr_q;
    end else if (rd_addr == ADR_PKLEN) begin
      rd_data = pklen_q;
    end else if (rd_addr == ADR_MODCTL) begin
      rd_data = modctl_q;
    end else if (rd_addr == ADR_TXAF) begin
      rd_data = txaf_q;
    end else if (rd_addr == ADR_TXAE) begin
      rd_data = txae_q;
    end else if (rd_addr == ADR_RXAF) begin
      rd_data = rxaf_q;
    end else if (rd_addr == ADR_FIFO) begin
      rd_data = rdata[1];
    end
  end

  // Plain configuration registers
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      irq_en_q <= 8'h00;
      fc2_q <= 8'h00;
      pkctrl_q <= RST_PKCTRL;
      prelen_q <= RST_PRELEN;
      sync_hi_q <= RST_SYNC_HI;
      sync_lo_q <= RST_SYNC_LO;
      txhdr_q <= 8'h00;
      pklen_q <= 8'h00;
      modctl_q <= 8'h00;
      txaf_q <= RST_TXAF;
      txae_q <= RST_TXAE;
      rxaf_q <= RST_RXAF;
    end else if (wr_stb) begin
      if (spi_addr_q == ADR_IRQ_EN) begin
        irq_en_q <= spi_byte;
      end else if (spi_addr_q == ADR_FC2) begin
        fc2_q <= spi_byte;
      end else if (spi_addr_q == ADR_PKCTRL) begin
        pkctrl_q <= spi_byte;
      end else if (spi_addr_q == ADR_PRELEN) begin
        prelen_q <= spi_byte;
      end else if (spi_addr_q == ADR_SYNC_HI) begin
        sync_hi_q <= spi_byte;
      end else if (spi_addr_q == ADR_SYNC_LO) begin
        sync_lo_q <= spi_byte;
      end else if (spi_addr_q == ADR_TXHDR) begin
        txhdr_q <= spi_byte;
      end else if (spi_addr_q == ADR_PKLEN) begin
        pklen_q <= spi_byte;
      end else if (spi_addr_q == ADR_MODCTL) begin
        modctl_q <= spi_byte;
      end else if (spi_addr_q == ADR_TXAF) begin
        txaf_q <= {2'b00, spi_byte[5:0]};
      end else if (spi_addr_q == ADR_TXAE) begin
        txae_q <= {2'b00, spi_byte[5:0]};
      end else if (spi_addr_q == ADR_RXAF) begin
        rxaf_q <= {2'b00, spi_byte[5:0]};
      end
    end
  end

  // Mode register; the sequencer drops transmit-on when a packet ends
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      opmode_q <= 8'h00;
    end else if (wr_stb && spi_addr_q == ADR_OPMODE) begin
      opmode_q <= spi_byte;
    end else if (tx_done) begin
      opmode_q[OPM_TXON] <= 1'b0;
      if (opmode_q == OPM_TXON_ONLY) begin
        opmode_q[OPM_XTON] <= 1'b1;
      end
    end
  end

  // FIFO port wiring: index 0 transmit, index 1 receive
  assign push[0] = wr_stb && spi_addr_q == ADR_FIFO;
  assign pop[0] = tx_pop;
  assign wdata[0] = spi_byte;
  assign clr[0] = fc2_q[FC2_CLRTX];
  assign push[1] = rx_push;
  assign pop[1] = rd_stb && rd_addr == ADR_FIFO;
  assign wdata[1] = rx_nbyte;
  assign clr[1] = fc2_q[FC2_CLRRX];

  // Both FIFOs share one structure; full pushes and empty pops are lost
  for (genvar g = 0; g < 2; g++) begin : g_fifo
    logic [7:0] mem [FIFO_DEPTH];
    logic [FIFO_AW-1:0] wp_q, rp_q;
    logic [FIFO_AW:0] cnt_q;
    logic do_push, do_pop;
    assign do_push = push[g] && !full[g];
    assign do_pop = pop[g] && !empty[g];
    assign full[g] = cnt_q == FIFO_DEPTH;
    assign empty[g] = cnt_q == '0;
    assign rdata[g] = mem[rp_q];
    assign cnt[g] = cnt_q;
    always_ff @(posedge clk_sys) begin
      if (do_push) begin
        mem[wp_q] <= wdata[g];
      end
    end
    always_ff @(posedge clk_sys) begin
      if (srst || clr[g]) begin
        wp_q <= '0;
        rp_q <= '0;
        cnt_q <= '0;
      end else begin
        wp_q <= wp_q + FIFO_AW'(do_push);
        rp_q <= rp_q + FIFO_AW'(do_pop);
        cnt_q <= cnt_q + (FIFO_AW+1)'(do_push) - (FIFO_AW+1)'(do_pop);
      end
    end
    always_ff @(posedge clk_sys) begin
      cnt_prev_q[g] <= srst ? '0 : cnt_q;
    end
  end

  // Events fire only on the crossing itself, not while above or below
  assign ev_txaf = cnt_prev_q[0] <= txaf_q[6:0]
                   && cnt[0] > txaf_q[6:0];
  assign ev_txae = tx_st_q != TX_IDLE && cnt_prev_q[0] >= txae_q[6:0]
                   && cnt[0] < txae_q[6:0];
  assign ev_rxaf = cnt_prev_q[1] <= rxaf_q[6:0]
                   && cnt[1] > rxaf_q[6:0];

  // Sticky status, cleared by reading it; a new event beats the clear
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      status_q <= 8'h00;
    end else begin
      if (rd_stb && rd_addr == ADR_STATUS) begin
        status_q <= 8'h00;
      end
      if (ev_txaf) status_q[ST_TXAF] <= 1'b1;
      if (ev_txae) status_q[ST_TXAE] <= 1'b1;
      if (ev_rxaf) status_q[ST_RXAF] <= 1'b1;
      if (ev_pksent) status_q[ST_PKSENT] <= 1'b1;
      if (ev_pkvalid) status_q[ST_PKVALID] <= 1'b1;
    end
  end

  // Only enabled sources pull the line low; status latches regardless
  always_ff @(posedge clk_sys) begin
    irq_n_q <= srst ? 1'b1 : ~|(status_q & irq_en_q);
  end

  // Bit-rate enable; host clock output toggles while oscillator runs
  always_ff @(posedge clk_sys) begin
    if (srst || div_q == BIT_LAST) begin
      div_q <= 12'h000;
    end else begin
      div_q <= div_q + 12'h001;
    end
    if (srst) begin
      mclk_q <= 1'b0;
    end else if (bit_en && opmode_q[OPM_XTON]) begin
      mclk_q <= ~mclk_q;
    end
  end
  assign bit_en = div_q == BIT_LAST;

  assign tx_load = bit_en && tx_bits_q == 3'h0 && tx_st_q != TX_IDLE;
  assign tx_pop = tx_load && tx_st_q == TX_DATA && !empty[0];
  // Without the handler the packet ends when the FIFO runs dry
  assign tx_done = tx_load && ((tx_st_q == TX_DATA && !pkctrl_q[PKC_ENTX]
                   && empty[0]) || (tx_st_q == TX_CRC
                   && (tx_idx_q != 8'h00 || !pkctrl_q[PKC_ENCRC])));
  assign ev_pksent = tx_done;

  // Transmit sequencer: one byte loaded per eight bit times
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      tx_st_q <= TX_IDLE;
      tx_sh_q <= 8'h00;
      tx_bits_q <= 3'h0;
      tx_idx_q <= 8'h00;
      tx_chk_q <= 8'h00;
    end else if (tx_st_q == TX_IDLE) begin
      tx_idx_q <= 8'h00;
      tx_chk_q <= 8'h00;
      tx_bits_q <= 3'h0;
      if (opmode_q[OPM_TXON]) begin
        tx_st_q <= pkctrl_q[PKC_ENTX] ? TX_PRE : TX_DATA;
      end
    end else if (tx_load) begin
      tx_bits_q <= 3'h7;
      tx_idx_q <= tx_idx_q + 8'h01;
      case (tx_st_q)
        TX_PRE: begin
          tx_sh_q <= PRE_BYTE;
          if (tx_idx_q + 8'h01 >= prelen_q) begin
            tx_st_q <= TX_SYNC;
            tx_idx_q <= 8'h00;
          end
        end
        TX_SYNC: begin
          tx_sh_q <= tx_idx_q[0] ? sync_lo_q : sync_hi_q;
          if (tx_idx_q[0]) tx_st_q <= TX_HDR;
        end
        TX_HDR: begin
          tx_sh_q <= txhdr_q;
          tx_chk_q <= txhdr_q;
          tx_st_q <= TX_LEN;
        end
        TX_LEN: begin
          tx_sh_q <= pklen_q;
          tx_chk_q <= tx_chk_q ^ pklen_q;
          tx_idx_q <= 8'h00;
          tx_st_q <= pklen_q == 8'h00 ? TX_CRC : TX_DATA;
        end
        TX_DATA: begin
          tx_sh_q <= rdata[0];
          tx_chk_q <= tx_chk_q ^ rdata[0];
          if (!pkctrl_q[PKC_ENTX] && empty[0]) begin
            tx_st_q <= TX_IDLE;
            tx_bits_q <= 3'h0;
          end else if (pkctrl_q[PKC_ENTX] && tx_idx_q + 8'h01 == pklen_q) begin
            tx_st_q <= TX_CRC;
            tx_idx_q <= 8'h00;
          end
        end
        TX_CRC: begin
          // Second visit, or check byte disabled: the packet has been shifted out
          if (tx_idx_q != 8'h00 || !pkctrl_q[PKC_ENCRC]) begin
            tx_st_q <= TX_IDLE;
            tx_bits_q <= 3'h0;
          end else begin
            tx_sh_q <= tx_chk_q;
          end
        end
        default: tx_st_q <= TX_IDLE;
      endcase
    end else if (bit_en && tx_bits_q != 3'h0) begin
      tx_sh_q <= {tx_sh_q[6:0], 1'b0};
      tx_bits_q <= tx_bits_q - 3'h1;
    end
  end

  // Transmit pin follows the shift register's top bit, MSB first
  always_ff @(posedge clk_sys) begin
    txd_q <= srst ? 1'b0 : tx_sh_q[7];
  end

  // Manchester pairs keep only the first half of each pair
  assign rx_bit_ok = bit_en && (!modctl_q[MOD_MANCH] || half_q);
  assign rx_bit = modctl_q[MOD_MANCH] ? man_first_q : pin_sync_q.rx_data;
  assign rx_nbyte = {rx_byte_q[6:0], rx_bit};
  assign rx_push = rx_bit_ok && rx_bits_q == 3'h7 && rx_st_q == RX_DATA;
  assign ev_pkvalid = rx_bit_ok && rx_bits_q == 3'h7 && rx_st_q == RX_CHK
                      && rx_nbyte == rx_chk_q;

  // Receive path: hunt preamble then sync, then bytes
  always_ff @(posedge clk_sys) begin
    if (srst || !opmode_q[OPM_RXON]) begin
      rx_st_q <= RX_HUNT;
      rx_sh_q <= 16'h0000;
      rx_byte_q <= 8'h00;
      rx_bits_q <= 3'h0;
      rx_left_q <= 8'h00;
      rx_chk_q <= 8'h00;
      alt_cnt_q <= 3'h0;
      pre_seen_q <= 1'b0;
      half_q <= 1'b0;
      man_first_q <= 1'b0;
    end else begin
      if (bit_en) begin
        half_q <= ~half_q;
        man_first_q <= pin_sync_q.rx_data;
      end
      if (rx_bit_ok) begin
        rx_sh_q <= {rx_sh_q[14:0], rx_bit};
        rx_byte_q <= rx_nbyte;
        rx_bits_q <= rx_bits_q + 3'h1;
        if (rx_st_q == RX_HUNT) begin
          rx_bits_q <= 3'h0;
          alt_cnt_q <= rx_bit != rx_sh_q[0] ?
                       (alt_cnt_q == PRE_MIN_BITS ? alt_cnt_q :
                       alt_cnt_q + 3'h1) : 3'h0;
          if (alt_cnt_q == PRE_MIN_BITS) pre_seen_q <= 1'b1;
          if (pre_seen_q && {rx_sh_q[14:0], rx_bit} ==
              {sync_hi_q, sync_lo_q}) begin
            // Raw mode passes everything after sync unchecked
            rx_st_q <= pkctrl_q[PKC_ENRX] ? RX_HDR : RX_DATA;
          end
        end else if (rx_bits_q == 3'h7) begin
          case (rx_st_q)
            RX_HDR: begin
              rx_chk_q <= rx_nbyte;
              rx_st_q <= RX_LEN;
            end
            RX_LEN: begin
              rx_chk_q <= rx_chk_q ^ rx_nbyte;
              rx_left_q <= rx_nbyte;
              rx_st_q <= rx_nbyte == 8'h00 ? RX_CHK : RX_DATA;
            end
            RX_DATA: begin
              rx_chk_q <= rx_chk_q ^ rx_nbyte;
              rx_left_q <= rx_left_q - 8'h01;
              if (pkctrl_q[PKC_ENRX] && rx_left_q == 8'h01) begin
                rx_st_q <= RX_CHK;
              end
            end
            default: begin
              rx_st_q <= RX_HUNT;
              pre_seen_q <= 1'b0;
              alt_cnt_q <= 3'h0;
            end
          endcase
        end
      end
    end
  end

  assign spi_sdo = sdo_q;
  assign rf_tx_data = txd_q;
  assign interrupt_line_n = irq_n_q;
  assign general_pin_two = mclk_q;
  assign tx_active = opmode_q[OPM_TXON];

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  sequence s_first_load;
    tx_load && tx_st_q == TX_PRE;
  endsequence
  property p_depth; cnt[0] <= FIFO_DEPTH && cnt[1] <= FIFO_DEPTH; endproperty
  a_depth: assert property (p_depth) else $error("fifo overflow");
  property p_push;
    push[0] && !pop[0] && !full[0] && !clr[0] |=> cnt[0] == $past(cnt[0]) + 1;
  endproperty
  a_push: assert property (p_push) else $error("tx push lost");
  property p_pop;
    pop[1] && !push[1] && !empty[1] && !clr[1] |=> cnt[1] == $past(cnt[1]) - 1;
  endproperty
  a_pop: assert property (p_pop) else $error("rx pop lost");
  property p_txaf; ev_txaf |=> status_q[ST_TXAF]; endproperty
  a_txaf: assert property (p_txaf) else $error("txaf not set");
  property p_done; tx_done |=> !opmode_q[OPM_TXON] ##1 tx_st_q == TX_IDLE;
  endproperty
  a_done: assert property (p_done) else $error("tx not left");
  property p_ready; tx_done && opmode_q == OPM_TXON_ONLY |=>
    opmode_q[OPM_XTON]; endproperty
  a_ready: assert property (p_ready) else $error("xtal dropped");
  property p_clr; clr[0] |=> cnt[0] == '0; endproperty
  a_clr: assert property (p_clr) else $error("tx clear failed");
  property p_mask; (status_q & irq_en_q) == 8'h00 |=> interrupt_line_n;
  endproperty
  a_mask: assert property (p_mask) else $error("masked irq");
  property p_pre; s_first_load |=> ##1 !rf_tx_data; endproperty
  a_pre: assert property (p_pre) else $error("preamble bit");
endmodule // rfq_top

//--- dv/rfq_host_model.sv
/*
  Host-side serial master model for rfq_top: framed byte transfers.
  Assumes clk_sys at 40 MHz and a 200 ns serial clock, idle low.
*/
`timescale 1ns/1ps
module rfq_host_model (
  input wire logic clk_sys,
  output logic spi_sclk,
  output logic spi_nsel_n,
  output logic spi_sdi,
  input wire logic spi_sdo
);
  initial begin
    spi_sclk = 1'b0;
    spi_nsel_n = 1'b1;
    spi_sdi = 1'b0;
  end
  // One byte MSB first; sdo sampled late in the low half
  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      spi_sclk <= 1'b0;
      spi_sdi <= tx[i];
      repeat (4) @(posedge clk_sys);
      rx[i] = spi_sdo;
      spi_sclk <= 1'b1;
      repeat (4) @(posedge clk_sys);
    end
  endtask
  // Clock parked low outside frames; sdi flipped so stale bits show
  task automatic fend();
    spi_sclk <= 1'b0;
    repeat (4) @(posedge clk_sys);
    spi_nsel_n <= 1'b1;
    spi_sdi <= ~spi_sdi;
    repeat (8) @(posedge clk_sys);
  endtask
  // Burst write; the data port address does not advance
  task automatic wrb(input logic [6:0] a, input logic [7:0] d, input int n);
    logic [7:0] junk;
    @(posedge clk_sys);
    spi_nsel_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    xbyte({1'b1, a}, junk);
    for (int k = 0; k < n; k++) xbyte(d + 8'(k), junk);
    fend();
  endtask
  // Single read; for the data port this pops two bytes, one as each byte completes
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    logic [7:0] junk;
    @(posedge clk_sys);
    spi_nsel_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    xbyte({1'b0, a}, junk);
    xbyte(8'h00, d);
    fend();
  endtask
endmodule // rfq_host_model

//--- dv/rfq_top_tb.sv
/*
  Self-checking bench for rfq_top: register reset values, thresholds,
  masking, FIFO clear and automatic mode exit after transmit.
  Assumes the host model drives the serial port; receive line idle.
*/
`timescale 1ns/1ps
module rfq_top_tb;
  import rfq_pkg::*;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic rf_rx_data = 1'b0;
  logic spi_sclk, spi_nsel_n, spi_sdi, spi_sdo;
  logic rf_tx_data, tx_active, interrupt_line_n, general_pin_two;
  int err_count = 0;
  int n_tests = 0;
  logic [7:0] mode_in [2] = '{8'h08, 8'h0a};
  logic [7:0] mode_out [2] = '{8'h01, 8'h02};
  // 40 MHz system clock
  always #12.5 clk_sys = ~clk_sys;
  rfq_host_model host (.clk_sys(clk_sys), .spi_sclk(spi_sclk),
    .spi_nsel_n(spi_nsel_n), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo));
  rfq_top uut (.clk_sys(clk_sys), .srst(srst), .spi_sclk(spi_sclk),
    .spi_nsel_n(spi_nsel_n), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo),
    .rf_rx_data(rf_rx_data), .rf_tx_data(rf_tx_data),
    .tx_active(tx_active), .interrupt_line_n(interrupt_line_n),
    .general_pin_two(general_pin_two));
  task automatic check(input string what, input logic [7:0] seen,
    input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rchk(input string what, input logic [6:0] a,
    input logic [7:0] exp);
    logic [7:0] d;
    host.rd(a, d);
    check(what, d, exp);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Empty the transmit FIFO; the clear bit is a level, so release it
  task automatic clr_tx();
    host.wrb(ADR_FC2, 8'h01, 1);
    host.wrb(ADR_FC2, 8'h00, 1);
  endtask
  // Main sequence
  initial begin
    int i;
    int rises;
    logic tx_prev;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    repeat (6) @(posedge clk_sys);
    rchk("fc2 reset", ADR_FC2, 8'h00);
    rchk("txaf reset", ADR_TXAF, 8'h37);
    rchk("txae reset", ADR_TXAE, 8'h04);
    rchk("rxaf reset", ADR_RXAF, 8'h37);
    rchk("unmapped", 7'h50, 8'h00);
    $display("reset values done");
    // Masked source: status set, line quiet
    host.wrb(ADR_TXAF, 8'hc2, 1);
    rchk("txaf upper bits", ADR_TXAF, 8'h02);
    host.wrb(ADR_FIFO, 8'h10, 3);
    check("irq masked", {7'h00, interrupt_line_n}, 8'h01);
    rchk("status masked", ADR_STATUS, 8'h40);
    // Cleared FIFO must cross the threshold again
    clr_tx();
    host.wrb(ADR_IRQ_EN, 8'h40, 1);
    host.wrb(ADR_FIFO, 8'h20, 3);
    check("irq txaf", {7'h00, interrupt_line_n}, 8'h00);
    rchk("status txaf", ADR_STATUS, 8'h40);
    host.wrb(ADR_FIFO, 8'h30, 1);
    check("irq once", {7'h00, interrupt_line_n}, 8'h01);
    $display("thresholds done");
    // Raw transmit of one byte for each start mode
    host.wrb(ADR_PKCTRL, 8'h80, 1);
    host.wrb(ADR_IRQ_EN, 8'h04, 1);
    for (int m = 0; m < 2; m++) begin
      clr_tx();
      host.wrb(ADR_FIFO, 8'ha5, 1);
      host.wrb(ADR_OPMODE, mode_in[m], 1);
      check("tx active", {7'h00, tx_active}, 8'h01);
      // Line idles low before the byte, so 8'ha5 gives four rising edges
      rises = 0;
      tx_prev = rf_tx_data;
      for (i = 0; i < 40000; i++) begin
        @(posedge clk_sys);
        if (rf_tx_data === 1'b1 && tx_prev === 1'b0) rises++;
        tx_prev = rf_tx_data;
        if (interrupt_line_n === 1'b0) break;
      end
      // A timeout is counted here and skips the remaining modes, going on to the standby check
      if (i == 40000) begin
        check("packet sent wait", {7'h00, interrupt_line_n}, 8'h00);
        break;
      end
      check("tx rises", 8'(rises), 8'h04);
      rchk("mode after tx", ADR_OPMODE, mode_out[m]);
      // Oscillator kept: the host clock pin must still toggle
      if (m == 0) begin
        tx_prev = general_pin_two;
        rises = 0;
        repeat (4100) begin
          @(posedge clk_sys);
          if (general_pin_two !== tx_prev) rises = 1;
        end
        check("host clock", 8'(rises), 8'h01);
      end
      check("tx idle", {7'h00, tx_active}, 8'h00);
      rchk("status sent", ADR_STATUS, 8'h04);
    end
    host.wrb(ADR_OPMODE, 8'h00, 1);
    rchk("standby mode", ADR_OPMODE, 8'h00);
    $display("transmit exits done");
    close_out();
  end
endmodule // rfq_top_tb
